// [integration_irq_and_protection_tb.sv]
// testbench: interrupt controller, bus monitor and watchdog
`timescale 1ns/1ps
module integration_irq_and_protection_tb;
  logic        mclk, rst_n, ext_term, cycle_done, transfer_error, vector_valid, got_err;
  logic        prot_ctrl_we, wdog_vector_we, wdog_service_we, cause_clear_we, internal_reset;
  logic [2:0]  int_req, irq_level;
  logic [3:0]  irq_pin_n;
  logic [5:0]  select_match, select_out;
  logic [7:0]  irq_mask, periph_vector, ext_vector, wr_data, irq_pending, vector_out;
  logic [7:0]  prot_ctrl, reset_cause, pwait, pvec, got_vec;
  logic [11:0] sel_rows [6];
  int          fails, n_checks, cyc, t_aa, i;
  sip_pkg::src_ctrl_s [7:0] src_ctrl;
  sip_pkg::bus_cycle_s      cycle;
  sip_core u_dut (.mclk, .rst_n, .irq_pin_n, .int_req, .src_ctrl, .irq_mask,
    .periph_vector, .select_match, .cycle, .ext_term, .ext_vector, .prot_ctrl_we,
    .prot_ctrl_wdata(wr_data), .wdog_vector_we, .wdog_service_we, .wr_data,
    .cause_clear_we, .irq_level, .irq_pending, .select_out, .ack_addr(), .cycle_done,
    .transfer_error, .vector_valid, .vector_out, .prot_ctrl, .reset_cause, .internal_reset);
  sip_far_model u_far (.mclk, .rst_n, .cycle, .cycle_done, .term_after(pwait),
    .vec_in(pvec), .ext_term, .ext_vector);
  always #50 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (fails == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // k: 0 protection, 1 vector, 2 service, 3 cause clear
  task automatic wr(input int k, input logic [7:0] d);
    wr_data = d;
    {prot_ctrl_we, wdog_vector_we, wdog_service_we, cause_clear_we} = 4'(4'h8 >> k);
    tick();
    {prot_ctrl_we, wdog_vector_we, wdog_service_we, cause_clear_we} = 4'h0;
    tick();
  endtask
  task automatic run(input logic ex, ak, input logic [2:0] lv, input logic [7:0] pw, pv);
    int n;
    pwait = pw;
    pvec = pv;
    got_err = 1'b0;
    got_vec = 8'h00;
    cycle = '{1'b1, ex, ak, lv};
    tick();
    cycle.start = 1'b0;
    for (n = 0; n < 60; n++) begin
      got_err |= (transfer_error === 1'b1);
      if (vector_valid === 1'b1) got_vec = vector_out;
      if (cycle_done === 1'b1) break;
      tick();
    end
    chk(8'(n < 60), 8'h01);
  endtask
  task automatic wait_lvl(input logic [2:0] lv);
    int n;
    for (n = 0; n < 20 && irq_level !== lv; n++) tick();
    chk(8'(irq_level), 8'(lv));
  endtask
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    {fails, n_checks, cyc} = '0;
    irq_pin_n = 4'hF;
    int_req = 3'h0;
    // level and priority per source; sources 2 and 4 share level 7, priorities 0 and 3
    src_ctrl = 48'h82AA7E239458;
    irq_mask = 8'h00;
    periph_vector = 8'h40;
    select_match = 6'h00;
    cycle = '0;
    {prot_ctrl_we, wdog_vector_we, wdog_service_we, cause_clear_we} = 4'h0;
    {wr_data, pwait, pvec} = '0;
    sel_rows = '{12'hFE0, 12'h041, 12'h184, 12'h610, 12'h000, 12'h8A0};
    repeat (3) tick();
    rst_n = 1'b1;
    chk(prot_ctrl, 8'h00);
    chk(reset_cause, sip_pkg::CAUSE_POWER);
    foreach (sel_rows[r]) begin
      select_match = sel_rows[r][11:6];
      repeat (2) tick();
      chk(8'(select_out), 8'(sel_rows[r][5:0]));
    end
    // monitor limit 15 cycles, watchdog irq mode, 512 cycles
    wr(0, 8'hF0);
    wr(0, 8'h00);
    chk(prot_ctrl, 8'hF0);
    repeat (300) tick();
    // service steps with other accesses between
    wr(2, 8'h55);
    wr(2, 8'h12);
    wr(1, 8'h77);
    repeat (100) tick();
    wr(2, 8'hAA);
    t_aa = cyc;
    run(1'b0, 1'b0, 3'h0, 8'h00, 8'h00);
    run(1'b1, 1'b0, 3'h0, 8'h03, 8'h00);
    chk(8'(got_err), 8'h00);
    run(1'b1, 1'b0, 3'h0, 8'h00, 8'h00);
    chk(8'(got_err), 8'h01);
    irq_pin_n = 4'hE;
    wait_lvl(3'h3);
    run(1'b1, 1'b1, 3'h3, 8'h02, 8'h5A);
    chk(got_vec, 8'h5A);
    run(1'b1, 1'b1, 3'h3, 8'h00, 8'h5A);
    chk(got_vec, sip_pkg::SPURIOUS_VECTOR);
    irq_pin_n = 4'hD;
    wait_lvl(3'h2);
    run(1'b1, 1'b1, 3'h2, 8'h00, 8'h00);
    chk(got_vec, 8'h1A);
    // level 7 pin: short pulse must stay latched
    irq_pin_n = 4'hB;
    repeat (3) tick();
    irq_pin_n = 4'hF;
    repeat (8) tick();
    chk(8'(irq_level), 8'h07);
    run(1'b1, 1'b1, 3'h7, 8'h00, 8'h00);
    chk(got_vec, 8'h1F);
    irq_mask = 8'h40;
    int_req = 3'h2;
    repeat (8) tick();
    chk(8'(irq_level), 8'h00);
    irq_mask = 8'h00;
    wait_lvl(3'h5);
    run(1'b0, 1'b1, 3'h5, 8'h00, 8'h00);
    chk(got_vec, 8'h1D);
    int_req = 3'h4;
    wait_lvl(3'h4);
    run(1'b0, 1'b1, 3'h4, 8'h00, 8'h00);
    chk(got_vec, 8'h40);
    int_req = 3'h0;
    while (cyc < t_aa + 480) tick();
    chk(8'(irq_pending[4]), 8'h00);
    for (i = 0; i < 100 && irq_pending[4] !== 1'b1; i++) tick();
    wait_lvl(3'h7);
    run(1'b0, 1'b1, 3'h7, 8'h00, 8'h00);
    chk(got_vec, 8'h77);
    rst_n = 1'b0;
    repeat (3) tick();
    rst_n = 1'b1;
    // reset mode is only reachable through a fresh reset
    wr(0, 8'hF8);
    for (i = 0; i < 600 && internal_reset !== 1'b1; i++) tick();
    repeat (3) tick();
    chk(reset_cause, sip_pkg::CAUSE_WATCHDOG);
    wr(3, 8'h00);
    chk(reset_cause, sip_pkg::CAUSE_WATCHDOG);
    wr(3, 8'h20);
    chk(reset_cause, 8'h00);
    finish_test();
  end
  // whole run is about 1500 cycles
  initial begin
    repeat (4000) @(posedge mclk);
    chk(8'h00, 8'h01);
    finish_test();
  end
endmodule

// [sip_core.sv]
// interrupt controller, bus monitor, watchdog and select priority
// Notes on behaviour
// - overlapping selects: only highest-numbered asserts
// - slow external cycle raises transfer error
// - internal cycles end in two clocks
// - monitor enable bit and timeout select
// - protection control writable once after reset
// - timed-out acknowledge gets spurious vector 24
// - watchdog timeout: reset or level-7 interrupt
// - watchdog reset silent, cause recorded
// - watchdog vector from write-only register
// - prescale and period set watchdog timeout
// - service 0x55 then 0xAA, others allowed
// - eight sources: four pins, four internal
// - level and priority per source control
// - present highest unmasked pending level
// - timers autovector; watchdog level 7 always
// - level 7 edge detected, others level
// - drive serviced level on address 4:2
// - autovector external: internal zero-wait termination
// - internal vectored source: internal acknowledge
// - status bits clear by writing one; watchdog reset clears power bit
// - acknowledge read: ones, level, zeros
`timescale 1ns/1ps
module sip_core (
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  input  wire logic [3:0]              irq_pin_n,
  input  wire logic [2:0]              int_req,
  input  sip_pkg::src_ctrl_s [7:0]     src_ctrl,
  input  wire logic [7:0]              irq_mask,
  input  wire logic [7:0]              periph_vector,
  input  wire logic [5:0]              select_match,
  input  sip_pkg::bus_cycle_s          cycle,
  input  wire logic                    ext_term,
  input  wire logic [7:0]              ext_vector,
  input  wire logic                    prot_ctrl_we,
  input  wire logic [7:0]              prot_ctrl_wdata,
  input  wire logic                    wdog_vector_we,
  input  wire logic                    wdog_service_we,
  input  wire logic [7:0]              wr_data,
  input  wire logic                    cause_clear_we,
  output logic [2:0]                   irq_level,
  output logic [7:0]                   irq_pending,
  output logic [5:0]                   select_out,
  output logic [31:0]                  ack_addr,
  output logic                         cycle_done,
  output logic                         transfer_error,
  output logic                         vector_valid,
  output logic [7:0]                   vector_out,
  output logic [7:0]                   prot_ctrl,
  output logic [7:0]                   reset_cause,
  output logic                         internal_reset
);

  function automatic logic [2:0] src_level(input sip_pkg::src_ctrl_s c, input int unsigned i);
    src_level = (i == sip_pkg::SRC_WDOG) ? sip_pkg::LEVEL_EDGE : c.level;
  endfunction

  function automatic logic src_autovector_select(input sip_pkg::src_ctrl_s c, input int unsigned i);
    if (i == sip_pkg::SRC_TMR1 || i == sip_pkg::SRC_TMR2)
      src_autovector_select = 1'b1;
    else if (i == sip_pkg::SRC_WDOG)
      src_autovector_select = 1'b0;
    else
      src_autovector_select = c.autovec;
  endfunction

  // three-stage sync on pins; a change counts once stages two and three agree
  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic [3:0] pin_s3;
  logic [3:0] pin_req;
  logic [7:0] src_raw;
  logic [7:0] src_prev;
  logic       wdog_irq;
  logic [7:0] edge_latch;

  always_ff @(posedge mclk) begin
    pin_s1 <= ~irq_pin_n;
    pin_s2 <= pin_s1;
    pin_s3 <= pin_s2;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n)
      pin_req <= 4'h0;
    else
      pin_req <= (pin_s2 == pin_s3) ? pin_s3 : pin_req;
  end

  assign src_raw = {int_req[2], int_req[1:0], wdog_irq, pin_req};

  // state of the bus cycle: idle, external or internal
  sip_pkg::bus_state_e state;
  sip_pkg::bus_state_e next_state;
  logic [2:0]          ack_lvl;
  logic                ack_cyc;
  logic [2:0]          win_idx;
  logic                win_valid;
  logic                ack_take;
  logic [9:0]          bm_count;
  logic [9:0]          bm_limit;
  logic                bm_timeout;
  logic [1:0]          int_count;

  // level 7 sources latched on rising edge, cleared at acknowledge
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      src_prev   <= 8'h00;
      edge_latch <= 8'h00;
    end else begin
      src_prev <= src_raw;
      for (int i = 0; i < 8; i++) begin
        if (src_raw[i] && !src_prev[i])
          edge_latch[i] <= 1'b1;
        else if (ack_take && win_idx == 3'(i))
          edge_latch[i] <= 1'b0;
      end
    end
  end

  logic [7:0] pend;
  always_comb begin
    for (int i = 0; i < 8; i++)
      pend[i] = (src_level(src_ctrl[i], i) == sip_pkg::LEVEL_EDGE) ? edge_latch[i]
                : (src_raw[i] && src_level(src_ctrl[i], i) != 3'h0);
  end

  // pick highest level, then priority field among unmasked
  logic [4:0] best_key;
  always_comb begin
    best_key  = 5'h00;
    win_idx   = 3'h0;
    win_valid = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (pend[i] && !irq_mask[i] &&
          (!win_valid || {src_level(src_ctrl[i], i), src_ctrl[i].prio} > best_key)) begin
        best_key  = {src_level(src_ctrl[i], i), src_ctrl[i].prio};
        win_idx   = 3'(i);
        win_valid = 1'b1;
      end
    end
  end

  // requests are sampled at acknowledge start; a vanished one goes spurious
  assign ack_take = state == sip_pkg::IDLE && cycle.start && cycle.ack_cycle;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_level   <= 3'h0;
      irq_pending <= 8'h00;
    end else begin
      irq_level   <= win_valid ? best_key[4:2] : 3'h0;
      irq_pending <= pend;
    end
  end

  logic [5:0] sel_pick;
  always_comb begin
    sel_pick = 6'h00;
    for (int i = 0; i < sip_pkg::N_SEL; i++)
      if (select_match[i])
        sel_pick = 6'h01 << i;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n)
      select_out <= 6'h00;
    else
      select_out <= sel_pick;
  end

  // acknowledge source attributes, captured at acknowledge start
  logic [2:0] ack_src;
  logic       ack_hit;
  logic       ack_autovector_select;
  logic       ack_ext;

  // limit from timeout select; restart per external cycle
  assign bm_limit = (prot_ctrl[sip_pkg::PC_BMT_HI:sip_pkg::PC_BMT_LO] == 2'h0) ? sip_pkg::BM_LIMIT_0 :
                    (prot_ctrl[sip_pkg::PC_BMT_HI:sip_pkg::PC_BMT_LO] == 2'h1) ? sip_pkg::BM_LIMIT_1 :
                    (prot_ctrl[sip_pkg::PC_BMT_HI:sip_pkg::PC_BMT_LO] == 2'h2) ? sip_pkg::BM_LIMIT_2 :
                    sip_pkg::BM_LIMIT_3;
  assign bm_timeout = state == sip_pkg::EXT_CYC && prot_ctrl[sip_pkg::PC_BME] &&
                      !ext_term && bm_count >= bm_limit;

  logic int_end;
  logic ext_end;
  // internal cycle lasts exactly two clocks
  assign int_end = state == sip_pkg::INT_CYC && int_count == sip_pkg::INT_DONE_CNT;
  assign ext_end = state == sip_pkg::EXT_CYC && (ext_term || bm_timeout);

  always_comb begin
    next_state = state;
    unique case (state)
      sip_pkg::IDLE:
        if (cycle.start)
          next_state = (cycle.ack_cycle ? (ack_take && win_valid &&
                        !src_autovector_select(src_ctrl[win_idx], win_idx) && win_idx < 3'h4)
                        : cycle.external) ? sip_pkg::EXT_CYC : sip_pkg::INT_CYC;
      sip_pkg::EXT_CYC:
        if (ext_end)
          next_state = sip_pkg::IDLE;
      sip_pkg::INT_CYC:
        if (int_end)
          next_state = sip_pkg::IDLE;
      default:
        next_state = sip_pkg::IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state     <= sip_pkg::IDLE;
      bm_count  <= 10'h000;
      int_count <= 2'h0;
      ack_cyc   <= 1'b0;
      ack_lvl   <= 3'h0;
      ack_src   <= 3'h0;
      ack_hit   <= 1'b0;
      ack_autovector_select  <= 1'b0;
      ack_ext   <= 1'b0;
    end else begin
      state     <= next_state;
      bm_count  <= (state == sip_pkg::EXT_CYC) ? bm_count + 10'h001 : 10'h000;
      int_count <= (state == sip_pkg::INT_CYC) ? int_count + 2'h1 : 2'h0;
      if (state == sip_pkg::IDLE && cycle.start) begin
        ack_cyc  <= cycle.ack_cycle;
        ack_lvl  <= cycle.ack_level;
        ack_src  <= win_idx;
        ack_hit  <= win_valid && best_key[4:2] == cycle.ack_level;
        ack_autovector_select <= src_autovector_select(src_ctrl[win_idx], win_idx);
        ack_ext  <= win_idx < 3'h4;
      end
    end
  end

  // autovector: base 24 plus acknowledged level
  logic [7:0] auto_vec;
  assign auto_vec = sip_pkg::AUTOVEC_BASE + {5'h00, ack_lvl};

  logic [7:0] wdog_vector;
  logic [7:0] next_vector;
  assign next_vector = (!ack_hit || bm_timeout) ? sip_pkg::SPURIOUS_VECTOR :
                       ack_autovector_select ? auto_vec :
                       ack_src == 3'(sip_pkg::SRC_WDOG) ? wdog_vector :
                       ack_ext ? ext_vector : periph_vector;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ack_addr       <= 32'h00000000;
      cycle_done     <= 1'b0;
      transfer_error <= 1'b0;
      vector_valid   <= 1'b0;
      vector_out     <= 8'h00;
    end else begin
      ack_addr       <= ack_take ? (sip_pkg::ACK_ADDR_BASE | {27'h0, cycle.ack_level, 2'h0})
                        : ack_addr;
      cycle_done     <= int_end || ext_end;
      // transfer error on monitor timeout, not for acknowledge
      transfer_error <= bm_timeout && !ack_cyc;
      vector_valid   <= ack_cyc && (int_end || ext_end);
      vector_out     <= (ack_cyc && (int_end || ext_end)) ? next_vector : vector_out;
    end
  end

  // protection control accepts first write only
  logic prot_locked;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prot_ctrl   <= sip_pkg::PROT_CTRL_RST;
      prot_locked <= 1'b0;
      wdog_vector <= sip_pkg::WDOG_VECTOR_RST;
    end else begin
      if (prot_ctrl_we && !prot_locked) begin
        prot_ctrl   <= prot_ctrl_wdata;
        prot_locked <= 1'b1;
      end
      if (wdog_vector_we)
        wdog_vector <= wr_data;
    end
  end

  // period from prescale and period field
  localparam int unsigned WD_W = sip_pkg::WD_CNT_W;
  logic [4:0]            wd_exp;
  logic [WD_W-1:0]       wd_count;
  logic                  wd_armed;
  logic                  wd_expire;
  assign wd_exp = 5'(sip_pkg::WD_EXP_BASE) +
                  {2'h0, prot_ctrl[sip_pkg::PC_SWT_HI:sip_pkg::PC_SWT_LO], 1'b0} +
                  {2'h0, prot_ctrl[sip_pkg::PC_SWP], 2'h0};
  assign wd_expire = prot_ctrl[sip_pkg::PC_SWE] && wd_count[wd_exp];

  // first step arms; second restarts; others leave sequence intact
  logic service_done;
  assign service_done = wdog_service_we && wr_data == sip_pkg::SERVICE_SECOND && wd_armed;

  // expiry raises reset or level-7 request
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wd_count       <= '0;
      wd_armed       <= 1'b0;
      wdog_irq       <= 1'b0;
      internal_reset <= 1'b0;
    end else begin
      if (service_done || !prot_ctrl[sip_pkg::PC_SWE] || wd_expire)
        wd_count <= '0;
      else
        wd_count <= wd_count + 1'b1;
      if (wdog_service_we && wr_data == sip_pkg::SERVICE_FIRST)
        wd_armed <= 1'b1;
      else if (service_done)
        wd_armed <= 1'b0;
      wdog_irq       <= wd_expire ? !prot_ctrl[sip_pkg::PC_WATCHDOG_RESET_OR_IRQ_SEL] : wdog_irq;
      // internal pulse only, no external indication
      internal_reset <= wd_expire && prot_ctrl[sip_pkg::PC_WATCHDOG_RESET_OR_IRQ_SEL];
    end
  end

  // cause kept across watchdog reset; write one clears, set wins
  logic wd_reset_seen;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reset_cause   <= sip_pkg::CAUSE_POWER;
      wd_reset_seen <= 1'b0;
    end else begin
      wd_reset_seen <= internal_reset;
      if (wd_reset_seen)
        reset_cause <= sip_pkg::CAUSE_WATCHDOG;
      else if (cause_clear_we)
        reset_cause <= reset_cause & ~wr_data;
    end
  end

endmodule

// [sip_core_props.sv]
// checker: port-level properties of the interrupt and protection core
`timescale 1ns/1ps
module sip_core_props (
  input wire logic            mclk,
  input wire logic            rst_n,
  input sip_pkg::bus_cycle_s  cycle,
  input wire logic            ext_term,
  input wire logic [5:0]      select_match,
  input wire logic [5:0]      select_out,
  input wire logic            prot_ctrl_we,
  input wire logic [7:0]      prot_ctrl,
  input wire logic            transfer_error,
  input wire logic            cycle_done,
  input wire logic [31:0]     ack_addr,
  input wire logic [7:0]      irq_pending,
  input wire logic [7:0]      irq_mask,
  input wire logic [2:0]      irq_level,
  input wire logic            vector_valid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence int_start; cycle.start && !cycle.external; endsequence
  sequence ack_start; cycle.start && cycle.ack_cycle; endsequence
  // written once: any nonzero value means the first write is done
  sequence wdog_req; irq_pending[4] && !irq_mask[4]; endsequence
  sel_prio_a: assert property (select_match[5] |=> select_out == 6'h20)
    else $error("top select not chosen alone");
  int_cycle_a: assert property (int_start |-> ##[2:3] cycle_done)
    else $error("internal cycle too slow");
  ext_done_a: assert property ($rose(ext_term) |=> cycle_done)
    else $error("terminated cycle not done");
  bm_gate_a: assert property (transfer_error |-> prot_ctrl[7])
    else $error("transfer error with monitor off");
  prot_once_a: assert property (prot_ctrl != 8'h00 && prot_ctrl_we |=> $stable(prot_ctrl))
    else $error("second protection write taken");
  ack_addr_a: assert property (ack_start |=> ack_addr == {27'h7FFFFFF, $past(cycle.ack_level), 2'h0})
    else $error("acknowledge address wrong");
  wdog_level_a: assert property (wdog_req [*3] |-> irq_level == 3'h7)
    else $error("watchdog request not at top level");
  vec_done_a: assert property (vector_valid |-> cycle_done)
    else $error("vector without cycle end");
endmodule
bind sip_core sip_core_props u_props (.mclk, .rst_n, .cycle, .ext_term, .select_match,
  .select_out, .prot_ctrl_we, .prot_ctrl, .transfer_error, .cycle_done, .ack_addr,
  .irq_pending, .irq_mask, .irq_level, .vector_valid);

// [sip_far_model.sv]
// far side model: external slave answering bus and acknowledge cycles
`timescale 1ns/1ps
module sip_far_model (
  input wire logic            mclk,
  input wire logic            rst_n,
  input sip_pkg::bus_cycle_s  cycle,
  input wire logic            cycle_done,
  input wire logic [7:0]      term_after,
  input wire logic [7:0]      vec_in,
  output logic                ext_term,
  output logic [7:0]          ext_vector
);
  logic       act;
  logic [7:0] cnt;
  // zero delay never answers, to starve the cycle on purpose
  wire logic  due = act && term_after != 8'h00 && cnt >= term_after;
  // vector on data byte, noise when released
  assign ext_vector = ext_term ? vec_in : ~cnt;
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      act <= 1'b0;
      cnt <= 8'h00;
      ext_term <= 1'b0;
    end else if (cycle.start && cycle.external && !act) begin
      act <= 1'b1;
      cnt <= 8'h01;
    end else if (act) begin
      cnt <= cnt + 8'h01;
      ext_term <= !cycle_done && (ext_term || due);
      act <= !cycle_done;
    end
  end
endmodule

// [sip_pkg.sv]
// package: constants and carriers for interrupt controller and protection logic
package sip_pkg;

  localparam int unsigned MCLK_HZ         = 10_000_000;
  localparam int unsigned N_SRC           = 8;
  localparam int unsigned N_SEL           = 6;
  // source index order: ext0..ext3, watchdog, timer1, timer2, serial
  localparam int unsigned SRC_WDOG        = 4;
  localparam int unsigned SRC_TMR1        = 5;
  localparam int unsigned SRC_TMR2        = 6;
  localparam logic [2:0]  LEVEL_EDGE      = 3'h7;
  localparam logic [7:0]  SPURIOUS_VECTOR = 8'h18;
  localparam logic [7:0]  AUTOVEC_BASE    = 8'h18;
  localparam logic [7:0]  SERVICE_FIRST   = 8'h55;
  localparam logic [7:0]  SERVICE_SECOND  = 8'hAA;
  localparam logic [7:0]  WDOG_VECTOR_RST = 8'h0F;
  localparam logic [7:0]  PROT_CTRL_RST   = 8'h00;
  localparam logic [7:0]  CAUSE_POWER     = 8'h80;
  localparam logic [7:0]  CAUSE_WATCHDOG  = 8'h20;
  // protection control field positions
  localparam int unsigned PC_BME          = 7;
  localparam int unsigned PC_BMT_HI       = 6;
  localparam int unsigned PC_BMT_LO       = 5;
  localparam int unsigned PC_SWE          = 4;
  localparam int unsigned PC_WATCHDOG_RESET_OR_IRQ_SEL         = 3;
  localparam int unsigned PC_SWP          = 2;
  localparam int unsigned PC_SWT_HI       = 1;
  localparam int unsigned PC_SWT_LO       = 0;
  // bus monitor limits per timeout select, in clock cycles
  localparam logic [9:0]  BM_LIMIT_0      = 10'h3FF;
  localparam logic [9:0]  BM_LIMIT_1      = 10'h0FF;
  localparam logic [9:0]  BM_LIMIT_2      = 10'h03F;
  localparam logic [9:0]  BM_LIMIT_3      = 10'h00F;
  // watchdog period exponent: 2^(9 + 2*period + 4*prescale) cycles
  localparam int unsigned WD_EXP_BASE     = 9;
  localparam int unsigned WD_CNT_W        = 24;
  localparam int unsigned INTERNAL_CYCLES = 2;
  localparam logic [1:0]  INT_DONE_CNT    = 2'(INTERNAL_CYCLES - 1);
  // acknowledge address: all ones above, level in [4:2], zeros in [1:0]
  localparam logic [31:0] ACK_ADDR_BASE   = 32'hFFFFFFE0;

  typedef struct packed {
    logic [2:0] level;
    logic [1:0] prio;
    logic       autovec;
  } src_ctrl_s;

  typedef struct packed {
    logic       start;
    logic       external;
    logic       ack_cycle;
    logic [2:0] ack_level;
  } bus_cycle_s;

  typedef enum logic [1:0] {
    IDLE    = 2'b00,
    EXT_CYC = 2'b01,
    INT_CYC = 2'b11
  } bus_state_e;

endpackage
